// file: verilog/rx_gain_mask.v
// receive gain configuration and mask timer behind an Avalon-MM slave
`timescale 1ns/10ps
`include "rx_gain_mask_defs.vh"

module rx_gain_mask (
    input wire mclk, // system clock, 20 MHz
    input wire nrst, // sync reset, active low
    input wire ce, // clock enable, freezes all state
    input wire [5:0] address, // word address, register index
    input wire read, // avalon read
    input wire write, // avalon write
    input wire [31:0] writedata, // avalon write data
    input wire [3:0] byteenable, // avalon byte enables
    output reg [31:0] readdata_r, // avalon read data
    output reg waitrequest_r, // avalon wait request
    input wire fc_tick, // carrier period pulse, same clock
    input wire tx_end, // end of transmit pulse, same clock
    output reg [7:0] first_gain_amplitude_channel, // half-dB, signed
    output reg [7:0] first_gain_phase_channel, // half-dB, signed
    output reg clip_en_r, // clip first and second stage
    output reg window_max_r, // comparator window forced widest
    output reg [2:0] win_amplitude_r, // AM digitizer window steps
    output reg [2:0] amp_amplitude_r, // AM amplifier cut steps
    output reg [2:0] win_phase_r, // PM digitizer window steps
    output reg [2:0] amp_phase_r, // PM amplifier cut steps
    output reg [7:0] agc_gain_code_r, // gain code seen by agc/rssi
    output reg gain_load_r, // one-cycle pulse on gain load
    output wire rx_mask_r, // receiver output ignored
    output wire squelch_r // squelch active
);

    ////////////////////////////////////////////////////////////////
    // clamp a later-stage code into the usable range
    function [3:0] clamp_code;
        input [3:0] code;
        begin
            if (code > `G23_CODE_MAX)
                clamp_code = `G23_CODE_MAX;
            else
                clamp_code = code;
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // register storage
    reg [7:0] first_stage_gain_r; // first stage, clip and force
    reg [7:0] second_third_stage_gain_r; // later stage codes
    reg [7:0] receive_mask_time_r; // mask count
    reg [2:0] control_r; // mode and squelch enables
    reg [7:0] loaded_gain_r; // copy held by gain control

    // bus decode
    wire req; // any request present
    wire wr_ok; // write hits low byte lane
    wire hit_first; // first stage register selected
    wire hit_later; // later stage register selected
    wire hit_mask; // mask register selected
    wire hit_cmd; // command register selected
    wire hit_ctl; // control register selected
    wire do_write; // write takes effect this edge
    wire set_default; // set-default command
    wire reset_gain; // reset-receive-gain command
    reg [7:0] rd_mux; // read data selection

    // per-channel decoded settings
    wire [7:0] dec_first [0:1]; // first stage gain per channel
    wire [2:0] dec_win [0:1]; // window steps per channel
    wire [2:0] dec_amp [0:1]; // amplifier steps per channel
    wire [2:0] code_first [0:1]; // first stage codes
    wire [3:0] code_later [0:1]; // later stage codes, loaded copy
    wire force_on; // peer gain force bit

    assign req = read | write;
    assign wr_ok = byteenable[0];
    assign hit_first = (address == `IDX_FIRST_STAGE_GAIN);
    assign hit_later = (address == `IDX_LATER_STAGE_GAIN);
    assign hit_mask = (address == `IDX_RECEIVE_MASK_TIME);
    assign hit_cmd = (address == `IDX_COMMAND);
    assign hit_ctl = (address == `IDX_CONTROL);

    // a write lands only at the edge where waitrequest is seen low
    assign do_write = write & ~waitrequest_r & wr_ok;
    assign set_default = do_write & hit_cmd &
        writedata[`CMD_SET_DEFAULT];
    assign reset_gain = do_write & hit_cmd &
        writedata[`CMD_RESET_RX_GAIN];

    assign force_on = first_stage_gain_r[`FS_FORCE];
    assign code_first[0] = first_stage_gain_r[`FS_AM_HI:`FS_AM_LO];
    assign code_first[1] = first_stage_gain_r[`FS_PM_HI:`FS_PM_LO];
    assign code_later[0] = loaded_gain_r[`LS_AM_HI:`LS_AM_LO];
    assign code_later[1] = loaded_gain_r[`LS_PM_HI:`LS_PM_LO];

    ////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped indices read as zero
    always @* begin
        case (address)
            `IDX_FIRST_STAGE_GAIN: rd_mux = first_stage_gain_r;
            `IDX_LATER_STAGE_GAIN: rd_mux = second_third_stage_gain_r;
            `IDX_RECEIVE_MASK_TIME: rd_mux = receive_mask_time_r;
            `IDX_CONTROL: rd_mux = {5'h00, control_r};
            `IDX_STATUS: rd_mux = {6'h00, squelch_r, rx_mask_r};
            `IDX_LOADED_GAIN: rd_mux = loaded_gain_r;
            default: rd_mux = 8'h00; // command reads zero too
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // avalon handshake: one wait cycle, then the answer
    // the idle high waitrequest costs a cycle but keeps it a flop
    always @(posedge mclk) begin
        if (!nrst) begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end else if (ce) begin
            if (req && waitrequest_r) begin
                // answer next edge, data already stable
                waitrequest_r <= 1'b0;
                readdata_r <= {24'h00_0000, rd_mux};
            end else begin
                // accepted or idle: back to waiting
                waitrequest_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // configuration registers
    always @(posedge mclk) begin
        if (!nrst) begin
            // power-up defaults
            first_stage_gain_r <= `RST_FIRST_STAGE_GAIN;
            second_third_stage_gain_r <= `RST_LATER_STAGE_GAIN;
            receive_mask_time_r <= `RST_RECEIVE_MASK_TIME;
            control_r <= `RST_CONTROL;
        end else if (ce) begin
            if (set_default) begin
                // command restores the same defaults
                first_stage_gain_r <= `RST_FIRST_STAGE_GAIN;
                second_third_stage_gain_r <=
                    `RST_LATER_STAGE_GAIN;
                receive_mask_time_r <= `RST_RECEIVE_MASK_TIME;
                control_r <= `RST_CONTROL;
            end else if (do_write) begin
                if (hit_first)
                    first_stage_gain_r <= writedata[7:0];
                if (hit_later)
                    // out-of-range codes saturate at Ah
                    second_third_stage_gain_r <= {
                        clamp_code(writedata[7:4]),
                        clamp_code(writedata[3:0])};
                if (hit_mask)
                    receive_mask_time_r <= writedata[7:0];
                if (hit_ctl)
                    control_r <= writedata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // copy of later stage gain used by agc, rssi and the channel decoders
    // writes alone never reach it; only the load command does
    always @(posedge mclk) begin
        if (!nrst) begin
            loaded_gain_r <= `RST_LATER_STAGE_GAIN;
            gain_load_r <= 1'b0;
        end else if (ce) begin
            gain_load_r <= reset_gain;
            if (reset_gain)
                loaded_gain_r <= second_third_stage_gain_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // channel decoders, AM is index 0, PM index 1
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            gain_decode u_dec (
                .first_code(code_first[ch]),
                .later_code(code_later[ch]),
                .force_on(force_on),
                .first_gain_hdb(dec_first[ch]),
                .win_steps(dec_win[ch]),
                .amp_steps(dec_amp[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // registered gain outputs to the analog stages
    // force takes effect without a load command, by design
    always @(posedge mclk) begin
        if (!nrst) begin
            first_gain_amplitude_channel <= 8'h00;
            first_gain_phase_channel <= 8'h00;
            clip_en_r <= 1'b0;
            window_max_r <= 1'b0;
            win_amplitude_r <= 3'h0;
            amp_amplitude_r <= 3'h0;
            win_phase_r <= 3'h0;
            amp_phase_r <= 3'h0;
            agc_gain_code_r <= `RST_LATER_STAGE_GAIN;
        end else if (ce) begin
            first_gain_amplitude_channel <= dec_first[0];
            first_gain_phase_channel <= dec_first[1];
            clip_en_r <= first_stage_gain_r[`FS_CLIP];
            window_max_r <= force_on;
            win_amplitude_r <= dec_win[0];
            amp_amplitude_r <= dec_amp[0];
            win_phase_r <= dec_win[1];
            amp_phase_r <= dec_amp[1];
            agc_gain_code_r <= loaded_gain_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mask timer; its outputs are flops inside the timer
    mask_timer u_mask (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .fc_tick(fc_tick),
        .tx_end(tx_end),
        .mask_value(receive_mask_time_r),
        .bitrate_detect(control_r[`CTL_BITRATE_DETECT]),
        .type_a_106(control_r[`CTL_TYPE_A_106]),
        .squelch_dyn(control_r[`CTL_SQUELCH_DYN]),
        .mask_r(rx_mask_r),
        .squelch_r(squelch_r)
    );

endmodule // rx_gain_mask

// file: verilog/rx_gain_mask_defs.vh
// register map, reset values, field positions and timing counts
`ifndef RX_GAIN_MASK_DEFS_VH
`define RX_GAIN_MASK_DEFS_VH

// register indices; byte address is four times the index
`define IDX_FIRST_STAGE_GAIN 6'h0C
`define IDX_LATER_STAGE_GAIN 6'h0D
`define IDX_RECEIVE_MASK_TIME 6'h0E
`define IDX_COMMAND 6'h18
`define IDX_CONTROL 6'h19
`define IDX_STATUS 6'h1A
`define IDX_LOADED_GAIN 6'h1B

// reset values
`define RST_FIRST_STAGE_GAIN 8'hD8
`define RST_LATER_STAGE_GAIN 8'h00
`define RST_RECEIVE_MASK_TIME 8'h08
`define RST_CONTROL 3'h0

// field positions
`define FS_AM_HI 7
`define FS_AM_LO 5
`define FS_PM_HI 4
`define FS_PM_LO 2
`define FS_CLIP 1
`define FS_FORCE 0
`define LS_AM_HI 7
`define LS_AM_LO 4
`define LS_PM_HI 3
`define LS_PM_LO 0
`define CMD_SET_DEFAULT 0
`define CMD_RESET_RX_GAIN 1
`define CTL_BITRATE_DETECT 0
`define CTL_TYPE_A_106 1
`define CTL_SQUELCH_DYN 2

// gain encoding, first stage in half-dB units, later stages in 3 dB steps
`define G1_STEP_HDB 8'h05
`define G1_BOOST_HDB 8'h0B
`define G1_BOOST_CODE 3'h7
`define G23_CODE_MAX 4'hA
`define G23_WIN_STEPS_MAX 4'h4
`define G23_WIN_FULL 3'h4
`define G23_FORCE_AMP_STEPS 3'h2

// mask timer, counted in carrier periods
`define MASK_STEP_FC 64
`define MASK_STEP_BRD_FC 512
`define STEP_LAST_FC 9'h03F
`define STEP_LAST_BRD_FC 9'h1FF
`define MASK_MIN_STEPS 8'h04
`define SQ_START_LAST_FC 9'h0FF
`define SQ_CNT_SAT 9'h100

`endif

// file: verilog/gain_decode.v
// one receive channel: gain codes to stage settings
`timescale 1ns/10ps
`include "rx_gain_mask_defs.vh"

module gain_decode (
    input wire [2:0] first_code, // first stage gain code
    input wire [3:0] later_code, // second/third stage code
    input wire force_on, // peer gain force
    output reg [7:0] first_gain_hdb, // signed gain, half-dB units
    output reg [2:0] win_steps, // digitizer window widening, 3 dB
    output reg [2:0] amp_steps // amplifier reduction, 3 dB
);

    reg [3:0] over; // code above the window-only range

    ////////////////////////////////////////////////////////////////
    // first stage: 0 full, 1..6 cut, 7 boost
    always @* begin
        case (first_code)
            3'h0: first_gain_hdb = 8'h00;
            `G1_BOOST_CODE: first_gain_hdb = `G1_BOOST_HDB;
            default: first_gain_hdb =
                8'h00 - ({5'h00, first_code} * `G1_STEP_HDB);
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // later stages: window first, then amplifier
    always @* begin
        over = later_code - `G23_WIN_STEPS_MAX;
        if (force_on) begin
            // forced: -6 dB in amplifiers, widest window
            win_steps = `G23_WIN_FULL;
            amp_steps = `G23_FORCE_AMP_STEPS;
        end else if (later_code <= `G23_WIN_STEPS_MAX) begin
            win_steps = later_code[2:0];
            amp_steps = 3'h0;
        end else begin
            win_steps = `G23_WIN_FULL;
            amp_steps = over[2:0];
        end
    end

endmodule // gain_decode

// file: verilog/mask_timer.v
// receive mask timer with dynamic squelch window
`timescale 1ns/10ps
`include "rx_gain_mask_defs.vh"

module mask_timer (
    input wire mclk, // system clock
    input wire nrst, // sync reset, active low
    input wire ce, // clock enable
    input wire fc_tick, // one pulse per carrier period
    input wire tx_end, // end of transmit pulse
    input wire [7:0] mask_value, // programmed mask count
    input wire bitrate_detect, // peer bit-rate detect mode
    input wire type_a_106, // type A 106 kbit/s mode
    input wire squelch_dyn, // dynamic squelch enable
    output reg mask_r, // receiver output masked
    output reg squelch_r // squelch active
);

    reg [8:0] pre_r; // carrier periods within one step
    reg [7:0] left_r; // steps still to run
    reg [8:0] sq_cnt_r; // carrier periods since end of transmit
    reg [7:0] target; // effective step count
    reg [8:0] step_last; // last carrier index of a step

    ////////////////////////////////////////////////////////////////
    // effective count and step length
    always @* begin
        if (type_a_106)
            target = mask_value;
        else if (mask_value < `MASK_MIN_STEPS)
            target = `MASK_MIN_STEPS;
        else
            target = mask_value;
        // bit-rate detect makes the step eight times longer, 512 carrier periods
        step_last = bitrate_detect ? `STEP_LAST_BRD_FC :
            `STEP_LAST_FC;
    end

    ////////////////////////////////////////////////////////////////
    // counting runs only on carrier ticks, so mclk rate is irrelevant
    always @(posedge mclk) begin
        if (!nrst) begin
            mask_r <= 1'b0;
            squelch_r <= 1'b0;
            pre_r <= 9'h000;
            left_r <= 8'h00;
            sq_cnt_r <= 9'h000;
        end else if (ce) begin
            if (tx_end) begin
                // restart on every end of transmit
                mask_r <= (target != 8'h00);
                left_r <= target;
                pre_r <= 9'h000;
                sq_cnt_r <= 9'h000;
                squelch_r <= 1'b0;
            end else if (mask_r && fc_tick) begin
                if (sq_cnt_r != `SQ_CNT_SAT)
                    sq_cnt_r <= sq_cnt_r + 9'h001;
                // squelch opens 256 carrier periods after transmit
                if (squelch_dyn && sq_cnt_r == `SQ_START_LAST_FC)
                    squelch_r <= 1'b1;
                if (pre_r == step_last) begin
                    pre_r <= 9'h000;
                    left_r <= left_r - 8'h01;
                    if (left_r == 8'h01) begin
                        // expiry ends both mask and squelch
                        mask_r <= 1'b0;
                        squelch_r <= 1'b0;
                    end
                end else begin
                    pre_r <= pre_r + 9'h001;
                end
            end
        end
    end

endmodule // mask_timer

// file: bench/rx_gain_mask_chk.sv
// checker: bus answer, gain decode and mask timer relations
`timescale 1ns/10ps
`include "rx_gain_mask_defs.vh"

module rx_gain_mask_chk (
    input wire mclk, // clock
    input wire nrst, // sync reset, active low
    input wire ce, // clock enable
    input wire [5:0] address, // register index
    input wire read, // bus read
    input wire write, // bus write
    input wire [31:0] writedata, // bus write data
    input wire [3:0] byteenable, // byte enables
    input wire waitrequest_r, // bus wait
    input wire fc_tick, // carrier tick
    input wire tx_end, // end of transmit
    input wire [7:0] first_gain_amplitude_channel, // am first gain
    input wire [7:0] first_gain_phase_channel, // pm first gain
    input wire clip_en_r, // clip enable
    input wire window_max_r, // forced window
    input wire [2:0] win_amplitude_r, // am window steps
    input wire [2:0] amp_amplitude_r, // am amp steps
    input wire [2:0] win_phase_r, // pm window steps
    input wire [2:0] amp_phase_r, // pm amp steps
    input wire [7:0] agc_gain_code_r, // loaded gain code
    input wire gain_load_r, // load pulse
    input wire rx_mask_r, // receiver masked
    input wire squelch_r // squelch active
);
    ////////////////////////////////////////////////////////////////////
    // accepted write to the first stage register
    wire wfs = write && !waitrequest_r && ce && byteenable[0] &&
        address == `IDX_FIRST_STAGE_GAIN;

    function [7:0] g1(input [2:0] c); // half-dB gain of a code
        g1 = (c == 3'h0) ? 8'h00 : (c == 3'h7) ? 8'h0B : 8'h00 - 8'h05 * c;
    endfunction
    function [2:0] wn(input [3:0] c); // window steps cap at four
        wn = (c > 4'h4) ? 3'h4 : c[2:0];
    endfunction
    function [2:0] am(input [3:0] c); // amp steps beyond four
        reg [3:0] d;
        d = c - 4'h4;
        am = (c > 4'h4) ? d[2:0] : 3'h0;
    endfunction

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////
    AST_BUS_ANSWER: assert property ((read || write) && waitrequest_r |=>
        !waitrequest_r ##1 waitrequest_r) else $error("bus answer late");
    AST_FG_AM: assert property (wfs |-> ##2
        first_gain_amplitude_channel == g1($past(writedata[7:5], 2)))
        else $error("am first gain wrong");
    AST_FG_PM: assert property (wfs |-> ##2
        first_gain_phase_channel == g1($past(writedata[4:2], 2)))
        else $error("pm first gain wrong");
    AST_CLIP: assert property (wfs |-> ##2
        clip_en_r == $past(writedata[1], 2) &&
        window_max_r == $past(writedata[0], 2)) else $error("clip wrong");
    AST_FORCE: assert property (window_max_r |->
        win_amplitude_r == 3'h4 && amp_amplitude_r == 3'h2 &&
        win_phase_r == 3'h4 && amp_phase_r == 3'h2)
        else $error("force steps wrong");
    AST_CODE_MAX: assert property (
        agc_gain_code_r[7:4] <= `G23_CODE_MAX &&
        agc_gain_code_r[3:0] <= `G23_CODE_MAX) else $error("code over max");
    AST_LATER_AM: assert property (!window_max_r |->
        win_amplitude_r == wn(agc_gain_code_r[7:4]) &&
        amp_amplitude_r == am(agc_gain_code_r[7:4])) else $error("am steps");
    AST_LATER_PM: assert property (!window_max_r |->
        win_phase_r == wn(agc_gain_code_r[3:0]) &&
        amp_phase_r == am(agc_gain_code_r[3:0])) else $error("pm steps");
    AST_LOAD: assert property (!$stable(agc_gain_code_r) |->
        $past(gain_load_r) || $past(gain_load_r, 2))
        else $error("gain code changed without load");
    AST_MASK_CAUSE: assert property ($rose(rx_mask_r) |->
        $past(tx_end)) else $error("mask rose without transmit end");
    AST_MASK_END: assert property ($fell(rx_mask_r) |->
        $past(fc_tick) || $past(tx_end)) else $error("mask fell off tick");
    AST_SQUELCH: assert property (squelch_r |-> rx_mask_r)
        else $error("squelch outside mask");
endmodule // rx_gain_mask_chk

bind rx_gain_mask rx_gain_mask_chk chk (.mclk(mclk), .nrst(nrst), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .waitrequest_r(waitrequest_r),
    .fc_tick(fc_tick), .tx_end(tx_end),
    .first_gain_amplitude_channel(first_gain_amplitude_channel),
    .first_gain_phase_channel(first_gain_phase_channel),
    .clip_en_r(clip_en_r), .window_max_r(window_max_r),
    .win_amplitude_r(win_amplitude_r), .amp_amplitude_r(amp_amplitude_r),
    .win_phase_r(win_phase_r), .amp_phase_r(amp_phase_r),
    .agc_gain_code_r(agc_gain_code_r), .gain_load_r(gain_load_r),
    .rx_mask_r(rx_mask_r), .squelch_r(squelch_r));

// file: bench/rx_gain_mask_tb.sv
// self-checking bench: register bus, gain decode and mask timer
`timescale 1ns/10ps
`include "rx_gain_mask_defs.vh"

module rx_gain_mask_tb;
    reg mclk = 1'b0; // 20 MHz
    reg nrst = 1'b0; // sync reset
    reg ce = 1'b1; // left running
    reg [5:0] address = 6'h00;
    reg read = 1'b0;
    reg write = 1'b0;
    reg [31:0] writedata = 32'h0;
    reg [3:0] byteenable = 4'hF;
    reg fc_tick = 1'b0; // random carrier ticks
    reg tx_end = 1'b0;
    wire [31:0] readdata_r;
    wire waitrequest_r, clip_en_r, window_max_r, gain_load_r;
    wire rx_mask_r, squelch_r;
    wire [7:0] fg_am, fg_pm, agc_gain_code_r;
    wire [2:0] win_am, amp_am, win_pm, amp_pm;
    integer seed = 32;
    integer n_mismatch = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i, t_mask, t_sq;
    reg [31:0] rd; // last read data
    reg [7:0] v, prev; // written value, last loaded code
    reg [3:0] c, p;
    reg [63:0] mvs = 64'h0003050802000204; // mask values
    reg [23:0] mcs = {3'd0, 3'd0, 3'd0, 3'd4, 3'd1, 3'd2, 3'd2, 3'd4};

    rx_gain_mask uut (.mclk(mclk), .nrst(nrst), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata_r(readdata_r),
        .waitrequest_r(waitrequest_r), .fc_tick(fc_tick), .tx_end(tx_end),
        .first_gain_amplitude_channel(fg_am),
        .first_gain_phase_channel(fg_pm), .clip_en_r(clip_en_r),
        .window_max_r(window_max_r), .win_amplitude_r(win_am),
        .amp_amplitude_r(amp_am), .win_phase_r(win_pm),
        .amp_phase_r(amp_pm), .agc_gain_code_r(agc_gain_code_r),
        .gain_load_r(gain_load_r), .rx_mask_r(rx_mask_r),
        .squelch_r(squelch_r));

    ////////////////////////////////////////////////////////////////////
    always #25 mclk = ~mclk;
    // ticks at random spacing so counts follow ticks, not cycles
    always @(posedge mclk) begin
        fc_tick <= 1'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end

    ////////////////////////////////////////////////////////////////////
    function [7:0] g1_exp(input [2:0] k); // half-dB first gain
        g1_exp = (k == 3'h0) ? 8'h00 : (k == 3'h7) ? 8'h0B : 8'h00 - 8'h05 * k;
    endfunction
    function [2:0] win_exp(input [3:0] k);
        win_exp = (k > 4'h4) ? 3'h4 : k[2:0];
    endfunction
    function [2:0] amp_exp(input [3:0] k);
        amp_exp = (k > 4'h4) ? 3'(k - 4'h4) : 3'h0;
    endfunction
    function integer ticks_exp(input [7:0] m, input [2:0] ctl);
        integer n;
        n = ctl[1] ? m : (m < 4 ? 4 : m); // floor of four steps
        ticks_exp = n * (ctl[0] ? 512 : 64);
    endfunction

    task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_cnt(input string nm, input integer e, input integer g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // request held until waitrequest is seen low at an edge
    task bus_wr(input [5:0] a, input [7:0] d, input [3:0] be = 4'hF);
        @(posedge mclk);
        write <= 1'b1;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        @(posedge mclk);
        while (waitrequest_r !== 1'b0) @(posedge mclk);
        write <= 1'b0;
    endtask
    task bus_rd(input [5:0] a);
        @(posedge mclk);
        read <= 1'b1;
        address <= a;
        @(posedge mclk);
        while (waitrequest_r !== 1'b0) @(posedge mclk);
        rd = readdata_r;
        read <= 1'b0;
    endtask
    task rd_chk(input [5:0] a, input [31:0] e);
        bus_rd(a);
        chk_val("register", e, rd);
    endtask

    task run_mask(input [7:0] m, input [2:0] ctl);
        bus_wr(`IDX_RECEIVE_MASK_TIME, m);
        bus_wr(`IDX_CONTROL, {5'h0, ctl});
        @(posedge mclk);
        tx_end <= 1'b1;
        @(posedge mclk);
        tx_end <= 1'b0;
        t_mask = 0;
        t_sq = 0;
        @(negedge mclk);
        while (rx_mask_r === 1'b1) begin
            if (fc_tick) t_mask = t_mask + 1;
            if (fc_tick && squelch_r) t_sq = t_sq + 1;
            @(negedge mclk);
        end
        chk_cnt("mask ticks", ticks_exp(m, ctl), t_mask);
        chk_cnt("squelch ticks", (ctl[2] && ticks_exp(m, ctl) > 256) ?
            ticks_exp(m, ctl) - 256 : 0, t_sq);
        $display("test mask %h mode %0d done", m, ctl);
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        prev = 8'h00;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(`IDX_FIRST_STAGE_GAIN, 32'hD8);
        rd_chk(`IDX_LATER_STAGE_GAIN, 32'h00);
        rd_chk(`IDX_RECEIVE_MASK_TIME, 32'h08);
        chk_val("am reset gain", 8'hE2, fg_am);
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            p = 4'($random(seed));
            v = {i[2:0], 3'h7 - i[2:0], p[0], 1'b0};
            bus_wr(`IDX_FIRST_STAGE_GAIN, v);
            rd_chk(`IDX_FIRST_STAGE_GAIN, v);
            chk_val("am gain", g1_exp(v[7:5]), fg_am);
            chk_val("pm gain", g1_exp(v[4:2]), fg_pm);
            chk_val("clip", v[1], clip_en_r);
        end
        bus_wr(`IDX_FIRST_STAGE_GAIN, 8'h01);
        rd_chk(`IDX_FIRST_STAGE_GAIN, 32'h01);
        chk_val("force", 1'b1, window_max_r);
        chk_val("steps", 12'h8A2, {win_am, amp_am, win_pm, amp_pm});
        bus_wr(`IDX_FIRST_STAGE_GAIN, 8'h00);
        $display("test first stage done");
        for (i = 0; i < 16; i = i + 1) begin
            p = 4'(($random(seed) & 32'hFF) % 11);
            c = (i > 10) ? 4'hA : i[3:0];
            bus_wr(`IDX_LATER_STAGE_GAIN, {i[3:0], p});
            rd_chk(`IDX_LATER_STAGE_GAIN, {c, p});
            chk_val("agc before load", prev, agc_gain_code_r);
            bus_wr(`IDX_COMMAND, 8'h02);
            prev = {c, p};
            rd_chk(`IDX_LOADED_GAIN, prev);
            chk_val("agc loaded", prev, agc_gain_code_r);
            chk_val("am win", win_exp(c), win_am);
            chk_val("am amp", amp_exp(c), amp_am);
            chk_val("pm win", win_exp(p), win_pm);
            chk_val("pm amp", amp_exp(p), amp_pm);
        end
        $display("test later stage done");
        bus_wr(6'h3F, 8'hFF);
        rd_chk(6'h3F, 32'h0);
        bus_wr(`IDX_RECEIVE_MASK_TIME, 8'h55, 4'hE);
        rd_chk(`IDX_RECEIVE_MASK_TIME, 32'h08);
        rd_chk(`IDX_COMMAND, 32'h0);
        $display("test refusals done");
        bus_wr(`IDX_FIRST_STAGE_GAIN, 8'h27);
        bus_wr(`IDX_LATER_STAGE_GAIN, 8'h99);
        bus_wr(`IDX_RECEIVE_MASK_TIME, 8'h11);
        bus_wr(`IDX_CONTROL, 8'h05);
        bus_wr(`IDX_COMMAND, 8'h01);
        rd_chk(`IDX_FIRST_STAGE_GAIN, 32'hD8);
        rd_chk(`IDX_LATER_STAGE_GAIN, 32'h00);
        rd_chk(`IDX_RECEIVE_MASK_TIME, 32'h08);
        rd_chk(`IDX_CONTROL, 32'h00);
        chk_val("agc kept", prev, agc_gain_code_r);
        $display("test set default done");
        for (i = 0; i < 8; i = i + 1)
            run_mask(mvs[8*i +: 8], mcs[3*i +: 3]);
        stop_test;
    end
endmodule // rx_gain_mask_tb
